// File: verilog/pis_defines.vh
`ifndef PIS_DEFINES_VH
`define PIS_DEFINES_VH

// Register byte offsets
`define PIS_ADDR_ELEC_COND   12'h000
`define PIS_ADDR_ELEC_EVENT  12'h004
`define PIS_ADDR_PRESS_COND  12'h008
`define PIS_ADDR_PRESS_EVENT 12'h00C
`define PIS_ADDR_CONTROL     12'h010
`define PIS_ADDR_COMMAND     12'h014
`define PIS_ADDR_FIL_STATE   12'h018

// Electronics field positions
`define PIS_BIT_POWER_ON     8
`define PIS_BIT_UNKNOWN_ERR  15

// Pressure field positions
`define PIS_BIT_FIL_OVERV    0
`define PIS_BIT_EMIS_UNDERI  1
`define PIS_BIT_START_TEST   2
`define PIS_BIT_AIN_VOLT     3
`define PIS_BIT_AIN_CURR     4
`define PIS_BIT_FOCUS_PLATE  5
`define PIS_PRESS_WIDTH      6

// Control fields
`define PIS_CTL_FIL_ILK      0
`define PIS_CTL_START_ILK    1
`define PIS_CTL_AIN_V_MON    2
`define PIS_CTL_AIN_I_MON    3
`define PIS_CTL_RESET        4'hF

// Command fields (write one to act)
`define PIS_CMD_ASSERT       0
`define PIS_CMD_FIL_START    1
`define PIS_CMD_FIL_STOP     2
`define PIS_CMD_CLR_PRESS    3

// Timing
`define PIS_TEST_TIME_US     100
`define PIS_CLK_MHZ          100

`endif

// File: verilog/pis_pressure_interlock_status.v
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "pis_defines.vh"

//**************************************************
// Pressure interlock and power-on status bank
//**************************************************

module pis_pressure_interlock_status #(
   parameter TEST_CYCLES = `PIS_TEST_TIME_US * `PIS_CLK_MHZ
) (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Fault detector pins
   input  wire        drvNearMax,
   input  wire        emisUnderCur,
   input  wire        testDone,
   input  wire        testPass,
   input  wire        ainVoltOver,
   input  wire        ainCurrOver,
   input  wire        focusSat,
   input  wire        dataCorrupt,
   // Filament and indicator
   output reg         testRun,
   output reg         filamentOn,
   output reg         pressureLamp
);

   //**************************************************
   // Input synchronisers
   //**************************************************
   // Detector pins are asynchronous: nothing reads them before the second flop
   reg [7:0] syncA_r;
   reg [7:0] syncB_r;
   always @(posedge clk) begin
      if (reset) begin
         syncA_r <= 8'h00;
         syncB_r <= 8'h00;
      end else begin
         syncA_r <= {dataCorrupt, focusSat, ainCurrOver, ainVoltOver,
                     testPass, testDone, emisUnderCur, drvNearMax};
         syncB_r <= syncA_r;
      end
   end
   wire sDrv   = syncB_r[0];
   wire sEmis  = syncB_r[1];
   wire sDone  = syncB_r[2];
   wire sPass  = syncB_r[3];
   wire sAinV  = syncB_r[4];
   wire sAinI  = syncB_r[5];
   wire sFocus = syncB_r[6];
   wire sCorr  = syncB_r[7];

   //**************************************************
   // Bus decode
   //**************************************************
   localparam [31:0] TEST_LEN = TEST_CYCLES;
   wire access   = psel && penable && pready;
   wire wrAccess = access && pwrite;
   wire rdAccess = access && !pwrite;

   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `PIS_ADDR_ELEC_COND) || (a == `PIS_ADDR_ELEC_EVENT) ||
                  (a == `PIS_ADDR_PRESS_COND) || (a == `PIS_ADDR_PRESS_EVENT) ||
                  (a == `PIS_ADDR_CONTROL) || (a == `PIS_ADDR_COMMAND) ||
                  (a == `PIS_ADDR_FIL_STATE);
      end
   endfunction

   //**************************************************
   // Interlock controls and commands
   //**************************************************
   reg [3:0] ctl_r;
   wire cmdWr    = wrAccess && (paddr == `PIS_ADDR_COMMAND);
   wire cmdAssert = cmdWr && pwdata[`PIS_CMD_ASSERT];
   wire cmdStart  = cmdWr && pwdata[`PIS_CMD_FIL_START];
   wire cmdStop   = cmdWr && pwdata[`PIS_CMD_FIL_STOP];
   wire cmdClrP   = cmdWr && pwdata[`PIS_CMD_CLR_PRESS];
   wire filIlk   = ctl_r[`PIS_CTL_FIL_ILK];
   wire startIlk = ctl_r[`PIS_CTL_START_ILK];

   always @(posedge clk) begin
      if (reset) begin
         ctl_r <= `PIS_CTL_RESET;
      end else if (wrAccess && paddr == `PIS_ADDR_CONTROL) begin
         ctl_r <= pwdata[3:0];
      end
   end

   //**************************************************
   // Filament sequencer
   //**************************************************
   localparam [1:0] ST_OFF  = 2'h0;
   localparam [1:0] ST_TEST = 2'h1;
   localparam [1:0] ST_ON   = 2'h2;

   reg [1:0]  state_r;
   reg [1:0]  state_nxt;
   reg [31:0] tmr_r;
   reg        testFail;
   reg [`PIS_PRESS_WIDTH-1:0] pressCond_r;
   reg [`PIS_PRESS_WIDTH-1:0] pressEvt_r;
   reg [`PIS_PRESS_WIDTH-1:0] faultSet;

   //**************************************************
   // Fault detection
   //**************************************************
   always @* begin
      faultSet = 6'h00;
      faultSet[`PIS_BIT_FIL_OVERV]   = filIlk && sDrv && state_r == ST_ON;
      faultSet[`PIS_BIT_EMIS_UNDERI] = filIlk && sEmis && state_r == ST_ON;
      faultSet[`PIS_BIT_START_TEST]  = testFail;
      faultSet[`PIS_BIT_AIN_VOLT]    = ctl_r[`PIS_CTL_AIN_V_MON] && sAinV;
      faultSet[`PIS_BIT_AIN_CURR]    = ctl_r[`PIS_CTL_AIN_I_MON] && sAinI;
      faultSet[`PIS_BIT_FOCUS_PLATE] = sFocus;
   end

   wire anyFault = |faultSet;

   // Test timeout counts as a failed test so the filament cannot hang
   always @* begin
      testFail  = 1'b0;
      state_nxt = state_r;
      case (state_r)
         ST_OFF: begin
            if (cmdStart) begin
               state_nxt = startIlk ? ST_TEST : ST_ON;
            end
         end
         ST_TEST: begin
            if (sDone && !sPass) begin
               testFail  = 1'b1;
               state_nxt = ST_OFF;
            end else if (tmr_r >= TEST_LEN - 32'h00000001 && !sDone) begin
               testFail  = 1'b1;
               state_nxt = ST_OFF;
            end else if (sDone && sPass) begin
               state_nxt = ST_ON;
            end
            // Stop also aborts a test in progress
            if (cmdStop) begin
               state_nxt = ST_OFF;
            end
         end
         ST_ON: begin
            if (cmdStop) begin
               state_nxt = ST_OFF;
            end
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
      // Any fault wins over start: filament stays down until next request
      if (anyFault && !testFail) begin
         state_nxt = ST_OFF;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         state_r <= ST_OFF;
         tmr_r   <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_TEST) begin
            tmr_r <= tmr_r + 32'h00000001;
         end else begin
            tmr_r <= 32'h00000000;
         end
      end
   end

   //**************************************************
   // Electronics status bits
   //**************************************************
   reg powerOnCond_r;
   reg powerOnEvt_r;
   reg unknownErr_r;
   reg unknownEvt_r;

   wire rdElecEvt  = rdAccess && paddr == `PIS_ADDR_ELEC_EVENT;
   wire rdPressEvt = rdAccess && paddr == `PIS_ADDR_PRESS_EVENT;

   // An unused sequencer code means the state register itself was upset
   wire stateBad = state_r == 2'h3;
   wire corrupt  = sCorr || stateBad;

   // Read clears only what the host was shown; a set during the access cycle survives
   always @(posedge clk) begin
      if (reset) begin
         powerOnCond_r <= 1'b1;
         powerOnEvt_r  <= 1'b1;
         unknownErr_r  <= 1'b0;
         unknownEvt_r  <= 1'b0;
      end else begin
         powerOnCond_r <= 1'b1;
         if (cmdAssert) begin
            powerOnEvt_r <= 1'b1;
         end else if (rdElecEvt && prdata[`PIS_BIT_POWER_ON]) begin
            powerOnEvt_r <= 1'b0;
         end
         if (corrupt) begin
            unknownErr_r <= 1'b1;
            unknownEvt_r <= 1'b1;
         end else if (rdElecEvt && prdata[`PIS_BIT_UNKNOWN_ERR]) begin
            unknownEvt_r <= 1'b0;
         end
      end
   end

   //**************************************************
   // Pressure status bits
   //**************************************************
   reg [`PIS_PRESS_WIDTH-1:0] pressCond_nxt;
   reg [`PIS_PRESS_WIDTH-1:0] pressEvt_nxt;

   // New faults always win over the clear command and the read-clear
   always @* begin
      pressCond_nxt = pressCond_r;
      if (cmdClrP) begin
         pressCond_nxt = {`PIS_PRESS_WIDTH{1'b0}};
      end
      pressCond_nxt = pressCond_nxt | faultSet;
      pressEvt_nxt  = pressEvt_r;
      if (rdPressEvt) begin
         pressEvt_nxt = pressEvt_r & ~prdata[`PIS_PRESS_WIDTH-1:0];
      end
      pressEvt_nxt = pressEvt_nxt | faultSet;
   end

   always @(posedge clk) begin
      if (reset) begin
         pressCond_r <= {`PIS_PRESS_WIDTH{1'b0}};
         pressEvt_r  <= {`PIS_PRESS_WIDTH{1'b0}};
      end else begin
         pressCond_r <= pressCond_nxt;
         pressEvt_r  <= pressEvt_nxt;
      end
   end

   //**************************************************
   // Outputs
   //**************************************************
   always @(posedge clk) begin
      if (reset) begin
         filamentOn   <= 1'b0;
         testRun      <= 1'b0;
         pressureLamp <= 1'b0;
      end else begin
         filamentOn   <= state_nxt == ST_ON;
         testRun      <= state_nxt == ST_TEST;
         pressureLamp <= |pressCond_nxt;
      end
   end

   //**************************************************
   // APB response
   //**************************************************
   reg [31:0] rdMux;

   // Read word is taken from the state seen in the setup cycle
   always @* begin
      rdMux = 32'h00000000;
      case (paddr)
         `PIS_ADDR_ELEC_COND: begin
            rdMux[`PIS_BIT_POWER_ON]    = powerOnCond_r;
            rdMux[`PIS_BIT_UNKNOWN_ERR] = unknownErr_r;
         end
         `PIS_ADDR_ELEC_EVENT: begin
            rdMux[`PIS_BIT_POWER_ON]    = powerOnEvt_r;
            rdMux[`PIS_BIT_UNKNOWN_ERR] = unknownEvt_r;
         end
         `PIS_ADDR_PRESS_COND: begin
            rdMux[`PIS_PRESS_WIDTH-1:0] = pressCond_r;
         end
         `PIS_ADDR_PRESS_EVENT: begin
            rdMux[`PIS_PRESS_WIDTH-1:0] = pressEvt_r;
         end
         `PIS_ADDR_CONTROL: begin
            rdMux[3:0] = ctl_r;
         end
         `PIS_ADDR_FIL_STATE: begin
            rdMux[1:0] = state_r;
         end
         default: begin
            rdMux = 32'h00000000;
         end
      endcase
   end

   // No wait state: pready rises after setup and drops after completion
   always @(posedge clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= !mapped(paddr);
      end else if (access) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Read data stands through the access cycle, then returns to zero
   always @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h00000000 : rdMux;
      end else if (access) begin
         prdata <= 32'h00000000;
      end
   end

endmodule

// File: verif/pis_pressure_interlock_status_monitor.sv
`timescale 1ns/1ps
module pis_pressure_interlock_status_monitor (
   // Clock and reset
   input wire        clk,
   input wire        reset,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   // Detectors and outputs
   input wire        drvNearMax,
   input wire        emisUnderCur,
   input wire        ainVoltOver,
   input wire        ainCurrOver,
   input wire        focusSat,
   input wire        testRun,
   input wire        filamentOn,
   input wire        pressureLamp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   reg  filIlk_r;
   reg  startIlk_r;
   reg  vMon_r;
   reg  iMon_r;
   wire done    = psel & penable & pready & pwrite;
   wire startWr = done & (paddr == 12'h014) & pwdata[1];
   // Shadow of interlock enables; reset value is all enabled
   always @(posedge clk) begin
      if (reset) begin
         filIlk_r   <= 1'b1;
         startIlk_r <= 1'b1;
         vMon_r     <= 1'b1;
         iMon_r     <= 1'b1;
      end else if (done && paddr == 12'h010) begin
         filIlk_r   <= pwdata[0];
         startIlk_r <= pwdata[1];
         vMon_r     <= pwdata[2];
         iMon_r     <= pwdata[3];
      end
   end
   a_apb_wait: assert property (psel && !penable |=> pready)
      else $error("pready missing in access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_drv_kills: assert property ((drvNearMax && filIlk_r && filamentOn)[*3] |-> ##[0:3] !filamentOn)
      else $error("drive fault left filament on");
   a_emis_kills: assert property ((emisUnderCur && filIlk_r && filamentOn)[*3] |-> ##[0:3] !filamentOn)
      else $error("emission fault left filament on");
   a_volt_kills: assert property ((ainVoltOver && vMon_r)[*3] |-> ##[0:3] !filamentOn)
      else $error("voltage fault left filament on");
   a_curr_kills: assert property ((ainCurrOver && iMon_r)[*3] |-> ##[0:3] !filamentOn)
      else $error("current fault left filament on");
   a_focus_lamp: assert property (focusSat[*3] |-> ##[0:3] (pressureLamp && !filamentOn))
      else $error("focus fault not shown");
   a_no_heat_test: assert property (!(testRun && filamentOn))
      else $error("filament heated during test");
   a_test_runs: assert property (startWr && startIlk_r && !filamentOn && !testRun |-> ##[1:3] testRun)
      else $error("start without pressure test");
   a_test_skip: assert property (startWr && !startIlk_r |=> (!testRun)[*4])
      else $error("test ran while bypassed");
   cover property (testRun ##[1:30] filamentOn);
   cover property (pslverr);
   cover property ($fell(filamentOn) && pressureLamp);
endmodule
bind pis_pressure_interlock_status pis_pressure_interlock_status_monitor mon (.*);

// File: verif/pis_pressure_interlock_status_test.sv
`timescale 1ns/1ps
module pis_pressure_interlock_status_test;
   reg         clk, reset, psel, penable, pwrite, testDone, testPass, dataCorrupt, startIlk;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, seed, r;
   reg  [5:0]  flt;
   reg         e;
   wire [31:0] prdata;
   wire        pready, pslverr, testRun, filamentOn, pressureLamp;
   integer     n_errors, n_compared, k, i;
   pis_pressure_interlock_status #(.TEST_CYCLES(20)) dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drvNearMax(flt[0]), .emisUnderCur(flt[1]),
      .testDone(testDone), .testPass(testPass), .ainVoltOver(flt[3]), .ainCurrOver(flt[4]),
      .focusSat(flt[5]), .dataCorrupt(dataCorrupt), .testRun(testRun), .filamentOn(filamentOn),
      .pressureLamp(pressureLamp));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function [31:0] pressExp(input integer b);
      begin
         pressExp = 32'h0000_0001 << b;
      end
   endfunction
   // Scaled stand-in for the host's pause after a failed start test
   localparam integer RETRY_GAP = 50;
   task wrap_up;
      begin
         $display("compared %0d, mismatches %0d", n_compared, n_errors);
         if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // One APB transfer; waits for pready, bounded
   task apb(input w, input [11:0] a, input [31:0] d);
      integer c;
      begin
         @(posedge clk);
         psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         c = 0;
         @(posedge clk);
         while (pready !== 1'b1 && c < 20) begin
            @(posedge clk);
            c = c + 1;
         end
         if (c >= 20) chk(1, 0);
         r = prdata;
         e = pslverr;
         psel <= 1'b0; penable <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(r, exp);
      end
   endtask
   task startFil(input pass);
      begin
         apb(1'b1, 12'h014, 32'h2);
         if (startIlk) begin
            i = 0;
            while (testRun !== 1'b1 && i < 30) begin @(posedge clk); i = i + 1; end
            testDone <= 1'b1; testPass <= pass;
            i = 0;
            while (testRun !== 1'b0 && i < 30) begin @(posedge clk); i = i + 1; end
            testDone <= 1'b0;
         end
         idle(3);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #300000;
      n_errors = n_errors + 1;
      wrap_up;
   end
   initial begin
      n_errors = 0; n_compared = 0; seed = 32'h0000_0039; startIlk = 1'b1;
      reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      testDone = 1'b0; testPass = 1'b0; dataCorrupt = 1'b0; flt = 6'h00;
      idle(8);
      reset <= 1'b0;
      rd(12'h000, 32'h0000_0100);
      rd(12'h004, 32'h0000_0100);
      rd(12'h004, 32'h0000_0000);
      rd(12'h010, 32'h0000_000F);
      apb(1'b1, 12'h014, 32'h1);
      rd(12'h004, 32'h0000_0100);
      apb(1'b1, 12'h000, 32'hFFFF_FFFF);
      rd(12'h000, 32'h0000_0100);
      dataCorrupt <= 1'b1;
      idle(4);
      dataCorrupt <= 1'b0;
      rd(12'h000, 32'h0000_8100);
      $display("status bits done");
      for (k = 0; k < 6; k = k + 1) begin
         seed = xs(seed);
         apb(1'b0, 12'h01C + {seed[7:0], 2'b00}, 32'h0);
         chk(e, 1);
         idle(seed[9:8]);
         if (k == 2) begin
            startFil(1'b0);
            idle(RETRY_GAP);
         end else begin
            startFil(1'b1);
            chk(filamentOn, 1);
            flt[k] <= 1'b1;
         end
         idle(8);
         chk({filamentOn, pressureLamp}, 2'b01);
         flt <= 6'h00;
         idle(8);
         chk(filamentOn, 0);
         rd(12'h008, pressExp(k));
         rd(12'h00C, pressExp(k));
         rd(12'h00C, 32'h0);
         apb(1'b1, 12'h014, 32'h8);
         idle(3);
         chk(pressureLamp, 0);
      end
      $display("fault loop done");
      apb(1'b1, 12'h010, 32'h2);
      startFil(1'b1);
      flt <= 6'h1B;
      idle(10);
      chk(filamentOn, 1);
      chk(pressureLamp, 0);
      rd(12'h008, 32'h0);
      rd(12'h018, 32'h0000_0002);
      flt <= 6'h00;
      apb(1'b1, 12'h014, 32'h4);
      apb(1'b1, 12'h010, 32'hD);
      startIlk = 1'b0;
      apb(1'b1, 12'h014, 32'h2);
      idle(6);
      chk({filamentOn, testRun}, 2'b10);
      $display("bypass tests done");
      wrap_up;
   end
endmodule
